// ===== rtl/parallel_io_port_map.svh
// Purpose: Register offsets, reset values and tie values of the parallel I/O port
// Assumes: Byte addresses on a 32-bit Avalon-MM bus, one aligned word per register
// Notes:   Definitions only
`ifndef PARALLEL_IO_PORT_MAP_SVH
`define PARALLEL_IO_PORT_MAP_SVH

// Register byte offsets
`define PIO_OFS_OPEN_DRAIN 4'h0
`define PIO_OFS_PIN_DATA   4'h4
`define PIO_OFS_DIRECTION  4'h8
`define PIO_OFS_ASSIGNMENT 4'hc

// Reset values of the control registers
`define PIO_RST_OPEN_DRAIN 16'h0000
`define PIO_RST_DIRECTION  16'h0000
`define PIO_RST_ASSIGNMENT 16'h0000

// Peripheral input levels when a pin is not handed over; bit 12 then follows master out, not this value
`define PIO_TIE_VALUE      16'hbb30

// Bit positions of the peripheral input functions, bit 0 is pin 16
`define PIO_BIT_SELECT          15
`define PIO_BIT_SERIAL_CLOCK    14
`define PIO_BIT_MASTER_OUT      13
`define PIO_BIT_MASTER_IN       12
`define PIO_BIT_TWO_WIRE_DATA   11
`define PIO_BIT_TWO_WIRE_CLOCK  10
`define PIO_BIT_UART_A_GENERAL  9
`define PIO_BIT_UART_B_GENERAL  8
`define PIO_BIT_UART_A_CLEAR    7
`define PIO_BIT_UART_B_CLEAR    6
`define PIO_BIT_UART_A_RECEIVE  5
`define PIO_BIT_UART_B_RECEIVE  4

// Only the low half of a bus word carries a register, so both low lanes are needed
`define PIO_FULL_WORD_BE   2'h3

`endif

// ===== rtl/parallel_io_port_pkg.sv
// Purpose: Types shared by the parallel I/O port and its bench
// Assumes: Sixteen pins
// Notes:   Offsets and values live in parallel_io_port_map.svh
`default_nettype none

package parallel_io_port_pkg;

  // What the on-chip peripherals offer to drive onto the pins
  typedef struct packed {
    logic [15:0] value;
    logic [15:0] enable;
  } periph_drive_t;

  // Pad-side drive of the port
  typedef struct packed {
    logic [15:0] value;
    logic [15:0] enable;
  } pad_drive_t;

endpackage : parallel_io_port_pkg

`default_nettype wire

// ===== rtl/parallel_io_port.sv
// Purpose: Sixteen-pin parallel I/O port with peripheral sharing and open drain
// Assumes: Avalon-MM slave, byte addresses, single clock clk_sys at 200 MHz
// Notes:   Pad outputs and peripheral inputs are registered, one cycle late
//
// The Avalon-MM register port and the register offsets were decided locally.
`default_nettype none
`include "parallel_io_port_map.svh"

module parallel_io_port
  import parallel_io_port_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic [3:0]    address,
  input  wire logic          read,
  input  wire logic          write,
  input  wire logic [31:0]   writedata,
  input  wire logic [3:0]    byteenable,
  output var  logic [31:0]   readdata,
  output var  logic          waitrequest,
  input  wire logic [15:0]   pin_in,
  output var  logic [15:0]   pin_out,
  output var  logic [15:0]   pin_oe,
  input  wire periph_drive_t periph_drive,
  output var  logic [15:0]   periph_in
);

  // The map and tie values are laid out for exactly sixteen pins
  if (WIDTH != 16) begin : g_width_check
    $error("parallel_io_port supports WIDTH = 16 only");
  end

  logic [15:0] open_drain_select_reg;
  logic [15:0] pin_direction_reg;
  logic [15:0] pin_assignment_reg;
  logic [15:0] pin_data_reg;
  logic [15:0] pin_meta;
  logic [15:0] pin_sync;
  logic        bus_req;
  logic        wr_take;
  logic        full_word;
  logic        wr_open_drain;
  logic        wr_data;
  logic        wr_direction;
  logic        wr_assignment;
  logic [15:0] handed;
  logic [15:0] gpio_out;
  pad_drive_t  next_pad;
  logic [15:0] next_tie;
  logic [15:0] next_periph_in;
  logic [31:0] next_readdata;

  // Two-stage synchroniser on the pads, the first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_meta <= 16'h0000;
      pin_sync <= 16'h0000;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // Bus handshake: one wait cycle, then the access completes
  assign bus_req   = read | write;
  assign wr_take   = write & ~waitrequest;
  assign full_word = (byteenable[1:0] == `PIO_FULL_WORD_BE);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~(bus_req & waitrequest);
    end
  end

  // Write strobes, one per register; a partial word is dropped rather than merged
  assign wr_open_drain = wr_take & full_word & (address == `PIO_OFS_OPEN_DRAIN);
  assign wr_data       = wr_take & full_word & (address == `PIO_OFS_PIN_DATA);
  assign wr_direction  = wr_take & full_word & (address == `PIO_OFS_DIRECTION);
  assign wr_assignment = wr_take & full_word & (address == `PIO_OFS_ASSIGNMENT);

  // Open-drain select, cleared so every output starts actively driven
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      open_drain_select_reg <= `PIO_RST_OPEN_DRAIN;
    end else if (wr_open_drain) begin
      open_drain_select_reg <= writedata[15:0];
    end
  end

  // Direction, cleared so every pin starts as an input
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_direction_reg <= `PIO_RST_DIRECTION;
    end else if (wr_direction) begin
      pin_direction_reg <= writedata[15:0];
    end
  end

  // Assignment, cleared so no pin starts out owned by a peripheral
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_assignment_reg <= `PIO_RST_ASSIGNMENT;
    end else if (wr_assignment) begin
      pin_assignment_reg <= writedata[15:0];
    end
  end

  // Output latch has no reset on purpose, software must write it before use
  always_ff @(posedge clk_sys) begin
    if (wr_data) begin
      pin_data_reg <= writedata[15:0];
    end
  end

  // Read mux: data offset shows the pads, not the latch
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address)
      `PIO_OFS_OPEN_DRAIN: next_readdata[15:0] = open_drain_select_reg;
      `PIO_OFS_PIN_DATA:   next_readdata[15:0] = pin_sync;
      `PIO_OFS_DIRECTION:  next_readdata[15:0] = pin_direction_reg;
      `PIO_OFS_ASSIGNMENT: next_readdata[15:0] = pin_assignment_reg;
      default:             next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data is captured while the wait cycle is shown and stands at the completing edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read && waitrequest) begin
      readdata <= next_readdata;
    end
  end

  // Ownership: a half-set assignment falls back to a plain input
  assign handed   = pin_assignment_reg & pin_direction_reg;
  assign gpio_out = ~pin_assignment_reg & pin_direction_reg;

  // Idle levels for peripheral inputs whose pin is not handed over
  always_comb begin
    next_tie                          = 16'h0000; // Output-only functions read nothing
    next_tie[`PIO_BIT_SELECT]         = 1'b1; // Slave select idles deasserted
    next_tie[`PIO_BIT_SERIAL_CLOCK]   = 1'b0;
    next_tie[`PIO_BIT_MASTER_OUT]     = 1'b1;
    next_tie[`PIO_BIT_MASTER_IN]      = periph_drive.value[`PIO_BIT_MASTER_OUT];
    next_tie[`PIO_BIT_TWO_WIRE_DATA]  = 1'b1; // A released two-wire bus reads high
    next_tie[`PIO_BIT_TWO_WIRE_CLOCK] = 1'b0;
    next_tie[`PIO_BIT_UART_A_GENERAL] = 1'b1;
    next_tie[`PIO_BIT_UART_B_GENERAL] = 1'b1;
    next_tie[`PIO_BIT_UART_A_CLEAR]   = 1'b0;
    next_tie[`PIO_BIT_UART_B_CLEAR]   = 1'b0;
    next_tie[`PIO_BIT_UART_A_RECEIVE] = 1'b1; // Idle line, so no false start bit
    next_tie[`PIO_BIT_UART_B_RECEIVE] = 1'b1;
  end

  // One slice per pin; bit i of every register and port is pin 16+i
  for (genvar i = 0; i < 16; i++) begin : g_pin
    logic drive_value;
    logic drive_enable;
    // A handed pin follows its peripheral, any other pin follows the latch
    assign drive_value        = handed[i] ? periph_drive.value[i] : pin_data_reg[i];
    assign drive_enable       = handed[i] ? periph_drive.enable[i] : gpio_out[i];
    // Open drain only ever pulls low, a one releases the wire
    assign next_pad.value[i]  = drive_value;
    assign next_pad.enable[i] = drive_enable & ~(open_drain_select_reg[i] & drive_value);
    // The peripheral sees the synchronised pad only while it owns the pin
    assign next_periph_in[i]  = handed[i] ? pin_sync[i] : next_tie[i];
  end

  // Pad value flops, so no pad sees a combinational glitch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_out <= 16'h0000;
    end else begin
      pin_out <= next_pad.value;
    end
  end

  // Pad enable flops, released at reset so every pin floats
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_oe <= 16'h0000;
    end else begin
      pin_oe <= next_pad.enable;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      periph_in <= `PIO_TIE_VALUE;
    end else begin
      periph_in <= next_periph_in;
    end
  end

endmodule : parallel_io_port

`default_nettype wire

// ===== testbench/parallel_io_port_asserts.sv
// Purpose: Bus and pad checks for the parallel I/O port
// Assumes: Shadow registers follow committed writes
// Notes:   Bound in the bench top file
`default_nettype none
`include "parallel_io_port_map.svh"
module parallel_io_port_asserts
  import parallel_io_port_pkg::*;
(
  input wire logic [3:0]  address,
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire periph_drive_t periph_drive,
  input wire logic [15:0] periph_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] od, dir, asg, dat, hq, eo, ev;
  wire cm = write && !waitrequest && byteenable[1:0] == 2'h3;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Shadow control registers, cleared like the real ones
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {od, dir, asg} <= '0;
    end else if (cm) begin
      if (address == `PIO_OFS_OPEN_DRAIN) od <= writedata[15:0];
      if (address == `PIO_OFS_DIRECTION) dir <= writedata[15:0];
      if (address == `PIO_OFS_ASSIGNMENT) asg <= writedata[15:0];
    end
  end
  // Latch has no reset, so unknown bits stay masked by direction
  always_ff @(posedge clk_sys) begin
    if (cm && address == `PIO_OFS_PIN_DATA) dat <= writedata[15:0];
  end
  // Expected pad drive, one cycle behind the registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      {hq, eo, ev} <= '0;
    end else begin
      hq <= asg & dir;
      eo <= (~asg & dir & ~(od & dat)) | (asg & dir & periph_drive.enable & ~(od & periph_drive.value));
      ev <= (~asg & dat) | (asg & periph_drive.value);
    end
  end
  property p_ws; !waitrequest |=> waitrequest; endproperty
  a_ws: assert property (p_ws) else $error("wait low too long");
  property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");
  property p_oe; pin_oe == eo; endproperty
  a_oe: assert property (p_oe) else $error("pad enable wrong");
  property p_out; (pin_out & pin_oe) == (ev & eo); endproperty
  a_out: assert property (p_out) else $error("pad value wrong");
  property p_tie; (periph_in & ~hq & 16'hefff) == (`PIO_TIE_VALUE & ~hq & 16'hefff); endproperty
  a_tie: assert property (p_tie) else $error("tie level wrong");
  property p_loop;
    !hq[`PIO_BIT_MASTER_IN] && !$past(rst) |->
      periph_in[`PIO_BIT_MASTER_IN] == $past(periph_drive.value[`PIO_BIT_MASTER_OUT]);
  endproperty
  a_loop: assert property (p_loop) else $error("master-in loop wrong");
  property p_rst; disable iff (1'b0) rst |-> pin_oe == 16'h0 && waitrequest; endproperty
  a_rst: assert property (p_rst) else $error("reset drive");
  property p_ctl; read && !waitrequest && address == `PIO_OFS_DIRECTION |-> readdata == {16'h0, dir}; endproperty
  a_ctl: assert property (p_ctl) else $error("direction readback");
  property p_unm; read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  c_hand: cover property (hq != 16'h0);
  c_wr: cover property (cm);
  c_rd: cover property (read && !waitrequest && address == `PIO_OFS_PIN_DATA);
endmodule : parallel_io_port_asserts
`default_nettype wire

// ===== testbench/pio_board.sv
// Purpose: Board side of the sixteen pads
// Assumes: Board drives ext wherever the port floats
// Notes:   Open-drain highs come from the board level
`default_nettype none
module pio_board (
  input  wire logic [15:0] pin_out,
  input  wire logic [15:0] pin_oe,
  input  wire logic [15:0] ext,
  output wire logic [15:0] pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Wire level from both parties
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule : pio_board
`default_nettype wire

// ===== testbench/test_parallel_io_port.sv
// Purpose: Random and corner register traffic against pad levels
// Assumes: One wait state per access
// Notes:   Pad reads wait out the sync lag
`default_nettype none
`include "parallel_io_port_map.svh"
module test_parallel_io_port import parallel_io_port_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys, rst = 0, read = 0, write = 0, waitrequest;
  logic [3:0] address = 0, byteenable = 0;
  logic [31:0] writedata = 0, readdata, q;
  logic [15:0] pin_in, pin_out, pin_oe, periph_in, ext = 0, a, r, o, t;
  periph_drive_t periph_drive = '0;
  int mismatches = 0, comparisons = 0;
  parallel_io_port i_dut (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .periph_drive(periph_drive), .periph_in(periph_in)
  );
  pio_board i_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Request held until wait drops, released after that edge
  task automatic xfer(bit w, logic [3:0] ad, logic [15:0] d, logic [3:0] be);
    int n = 0;
    address <= ad;
    writedata <= {16'h0, d};
    byteenable <= be;
    write <= w;
    read <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      finish_test();
    end
    q = readdata;
    read <= 0;
    write <= 0;
    @(posedge clk_sys);
  endtask : xfer
  function automatic logic [15:0] lvl(logic [15:0] d, od, dr, as, pv, pe, ex);
    logic [15:0] oe = (~as & dr & ~(od & d)) | (as & dr & pe & ~(od & pv));
    return (oe & ((~as & d) | (as & dr & pv))) | (~oe & ex);
  endfunction : lvl
  initial begin
    clk_sys = 0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    void'($urandom(28120));
    rst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    // Reset values and an unmapped place
    for (int k = 0; k < 4; k++) begin
      xfer(0, 4'(k * 4 + (k == 1 ? 2 : 0)), 16'h0, 4'hf);
      chk(q, 32'h0);
    end
    for (int i = 0; i < 40; i++) begin
      t = 16'($urandom);
      o = (i == 2) ? 16'hffff : 16'($urandom);
      a = (i == 1 || i == 2) ? 16'hffff : (i == 0 ? 16'h0 : 16'($urandom));
      r = (i == 1) ? 16'h0 : (i == 0 || i == 2 ? 16'hffff : 16'($urandom));
      ext <= 16'($urandom);
      periph_drive <= $urandom;
      xfer(1, `PIO_OFS_PIN_DATA, t, 4'h3);
      xfer(1, `PIO_OFS_OPEN_DRAIN, o, 4'h3);
      xfer(1, `PIO_OFS_DIRECTION, r, 4'h3);
      xfer(1, `PIO_OFS_ASSIGNMENT, a, 4'h3);
      xfer(1, `PIO_OFS_DIRECTION, ~r, 4'h1);
      repeat (4) @(posedge clk_sys);
      xfer(0, `PIO_OFS_PIN_DATA, 16'h0, 4'hf);
      chk(q, {16'h0, lvl(t, o, r, a, periph_drive.value, periph_drive.enable, ext)});
      xfer(0, `PIO_OFS_DIRECTION, 16'h0, 4'hf);
      chk(q, {16'h0, r});
      xfer(0, `PIO_OFS_ASSIGNMENT, 16'h0, 4'hf);
      chk(q, {16'h0, a});
      xfer(0, `PIO_OFS_OPEN_DRAIN, 16'h0, 4'hf);
      chk(q, {16'h0, o});
      $display("test %0d done", i);
    end
    // Mid-run reset clears the controls but leaves the output latch alone
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    xfer(0, `PIO_OFS_DIRECTION, 16'h0, 4'hf);
    chk(q, 32'h0);
    xfer(0, `PIO_OFS_OPEN_DRAIN, 16'h0, 4'hf);
    chk(q, 32'h0);
    xfer(1, `PIO_OFS_DIRECTION, 16'hffff, 4'h3);
    repeat (4) @(posedge clk_sys);
    xfer(0, `PIO_OFS_PIN_DATA, 16'h0, 4'hf);
    chk(q, {16'h0, t});
    $display("test reset done");
    finish_test();
  end
endmodule : test_parallel_io_port

bind parallel_io_port parallel_io_port_asserts i_chk (
  .address(address), .clk_sys(clk_sys), .rst(rst), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .pin_out(pin_out), .pin_oe(pin_oe), .periph_drive(periph_drive), .periph_in(periph_in)
);
`default_nettype wire
